// ### shared/dcf_pkg.sv
// constants and carrier types shared by the fifo design files
package dcf_pkg;
  localparam int DCF_DW = 18; // word width
  localparam int DCF_AW = 8; // address width for 256 words
  localparam int DCF_OW = 12; // offset register width
  localparam logic [8:0] DCF_DEPTH_CNT = 9'h100; // memory depth in words
  localparam logic [8:0] DCF_CNT_ZERO = 9'h000;
  localparam logic [8:0] DCF_CNT_ONE = 9'h001;
  localparam logic [12:0] DCF_DEPTH_WIDE = 13'h0100; // depth for offset compares
  localparam logic [12:0] DCF_HALF_WIDE = 13'h0080; // half of depth
  localparam logic [7:0] DCF_PTR_ZERO = 8'h00;
  localparam logic [7:0] DCF_PTR_ONE = 8'h01;
  localparam logic [11:0] DCF_OFS_DEFAULT = 12'h01f; // offset default for 256 deep
  localparam logic [17:0] DCF_DATA_ZERO = 18'h0_0000;
  localparam logic [5:0] DCF_OFS_PAD = 6'h00; // upper data bits on offset readback
  localparam logic [1:0] DCF_VIS_ZERO = 2'h0;
  localparam int DCF_VIS_LAST = 1; // last stage of the write visibility delay

  // flag pins, all active low
  typedef struct packed {
    logic full_flag_n; // full flag, or input ready in fall-through timing
    logic almost_full_n;
    logic half_full_n;
    logic almost_empty_n;
    logic empty_flag_n; // empty flag, or output ready in fall-through timing
  } dcf_flags_type;

  // three-state output bus: value plus drive enable
  typedef struct packed {
    logic [DCF_DW-1:0] data_out;
    logic data_out_oe;
  } dcf_qbus_type;
endpackage

// ### hw/dcf_word_store.sv
// word array of the fifo: one write port, one combinational read port
`timescale 1ns/1ns
module dcf_word_store
  import dcf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [DCF_AW-1:0] wr_addr,
  input wire logic [DCF_DW-1:0] wr_data,
  input wire logic [DCF_AW-1:0] rd_addr,
  output logic [DCF_DW-1:0] rd_data
);
  logic [DCF_DW-1:0] mem_r [0:(1<<DCF_AW)-1]; // storage, not reset on purpose

  // write port
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // read is combinational; the caller registers it into the output register
  assign rd_data = mem_r[rd_addr];
endmodule

// ### hw/dcf_offset_regs.sv
// almost-empty and almost-full threshold registers with rotating pointers
`timescale 1ns/1ns
module dcf_offset_regs
  import dcf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [DCF_OW-1:0] wr_data,
  input wire logic rd_en,
  output logic [DCF_OW-1:0] almost_empty_threshold,
  output logic [DCF_OW-1:0] almost_full_threshold,
  output logic [DCF_OW-1:0] rd_data
);
  logic [DCF_OW-1:0] ae_r, ae_nxt; // empty offset
  logic [DCF_OW-1:0] af_r, af_nxt; // full offset
  logic wsel_r, wsel_nxt; // 0 = empty offset next, 1 = full offset next
  logic rsel_r, rsel_nxt; // readback pointer, independent of wsel

  // next state of offsets and both pointers
  always_comb begin
    ae_nxt = ae_r;
    af_nxt = af_r;
    wsel_nxt = wsel_r;
    rsel_nxt = rsel_r;
    if (rst) begin
      ae_nxt = DCF_OFS_DEFAULT; // RQ4 RQ26
      af_nxt = DCF_OFS_DEFAULT; // RQ4 RQ26
      wsel_nxt = 1'b0;
      rsel_nxt = 1'b0;
    end else begin
      if (wr_en) begin
        // strict rotation; pointer survives leaving load mode
        if (wsel_r) begin
          af_nxt = wr_data; // RQ16 RQ17
        end else begin
          ae_nxt = wr_data; // RQ16 RQ17
        end
        wsel_nxt = ~wsel_r; // RQ17 RQ18
      end
      // edges without a write enable leave wsel untouched
      if (rd_en) begin
        rsel_nxt = ~rsel_r; // RQ20
      end
    end
  end

  // registers only
  always_ff @(posedge clk_sys) begin
    ae_r <= ae_nxt;
    af_r <= af_nxt;
    wsel_r <= wsel_nxt;
    rsel_r <= rsel_nxt;
  end

  assign almost_empty_threshold = ae_r;
  assign almost_full_threshold = af_r;
  assign rd_data = rsel_r ? af_r : ae_r; // RQ20

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  ofs_rotate_a: assert property (wr_en |=> wsel_r != $past(wsel_r)) // RQ17
    else $error("offset write pointer did not advance");
  ofs_idle_a: assert property (!wr_en |=> $stable(wsel_r) && $stable(ae_r) && $stable(af_r)) // RQ19
    else $error("offset state changed without a write");
  ofs_target_a: assert property (wr_en && !wsel_r |=> ae_r == $past(wr_data) && $stable(af_r)) // RQ17
    else $error("first offset write missed the empty offset");
endmodule

// ### hw/dcf_fifo.sv
// 256 x 18 fifo with standard and fall-through timing and threshold flags
// Notes on behaviour
// (RQ1) reset returns both pointers to location zero
// (RQ2) reset: half, almost-full, full high; almost-empty low
// (RQ3) reset empty flag low standard, high fall-through
// (RQ4) reset zeroes output register, loads default offsets
// (RQ5) write stores next location unless full
// (RQ6) write enable high writes nothing
// (RQ7) standard full flag low when full, clock updated
// (RQ8) standard full flag low after depth writes
// (RQ9) fall-through input ready high after depth plus one
// (RQ10) writes ignored while full in either mode
// (RQ11) read loads output register; otherwise it holds
// (RQ12) standard: every word requested, empty reads ignored
// (RQ13) fall-through first word appears on third edge
// (RQ14) fall-through output ready rises on a true read
// (RQ15) output enable low drives bus, high floats it
// (RQ16) two 12-bit offsets written from low data bits
// (RQ17) offset writes rotate empty, full, empty again
// (RQ18) offset write pointer persists outside load mode
// (RQ19) load low, write enable high: nothing happens
// (RQ20) offset readback rotates with its own pointer
// (RQ21) offset readback only in standard timing
// (RQ22) other side never reads and writes offsets together
// (RQ23) almost-empty low at offset words, plus one fall-through
// (RQ24) almost-full low at depth minus offset, plus one
// (RQ25) half-full low above half, high at or below
// (RQ26) default offsets are 31 for this depth
// (RQ27) straps sampled in reset pick timing and flag mode
`timescale 1ns/1ns
module dcf_fifo
  import dcf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [DCF_DW-1:0] data_in,
  input wire logic write_enable_n,
  input wire logic load_select_n,
  input wire logic read_enable_n,
  input wire logic output_enable_n,
  input wire logic first_load_n,
  input wire logic read_expand_in_n,
  input wire logic write_expand_in_n,
  output dcf_qbus_type qbus,
  output dcf_flags_type flags,
  output logic partial_flags_sync
);
  // mode straps, held from reset to reset
  logic fall_through_timing_r, fall_through_timing_nxt; // fall-through timing selected
  logic psync_r, psync_nxt; // synchronous partial flags selected
  // pointers and counts
  logic [DCF_AW-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [DCF_AW-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [8:0] mem_cnt_r, mem_cnt_nxt; // words held in the array
  logic [8:0] vis_cnt_r, vis_cnt_nxt; // words the read side may take
  logic [DCF_VIS_LAST:0] vis_pipe_r, vis_pipe_nxt; // write visibility delay
  logic out_valid_r, out_valid_nxt; // fall-through: output register holds a word
  logic [DCF_DW-1:0] dout_r, dout_nxt; // output register
  dcf_flags_type flags_r, flags_nxt;
  // decoded events
  logic full_now; // full as last flagged, blocks writes
  logic wr_acc; // word written this edge
  logic pop; // word moved from array to output register
  logic ofs_wr; // offset register write
  logic ofs_rd; // offset register readback
  logic [DCF_DW-1:0] mem_rdata;
  logic [DCF_OW-1:0] ofs_rdata;
  logic [DCF_OW-1:0] ae_thr;
  logic [DCF_OW-1:0] af_thr;
  logic [8:0] words_nxt; // occupancy including output register in fall-through
  logic [12:0] words_wide;

  // in fall-through the flag bit is input ready, high meaning full
  assign full_now = fall_through_timing_r ? flags_r.full_flag_n : ~flags_r.full_flag_n;

  // request decode
  always_comb begin
    wr_acc = ~write_enable_n & load_select_n & ~full_now; // RQ5 RQ6 RQ10
    ofs_wr = ~write_enable_n & ~load_select_n; // RQ16 RQ19
    ofs_rd = ~read_enable_n & ~load_select_n & ~fall_through_timing_r; // RQ20 RQ21
    if (fall_through_timing_r) begin
      // auto-load into an empty output register, else only on a true read
      pop = (vis_cnt_r != DCF_CNT_ZERO) &
        (~out_valid_r | (~read_enable_n & load_select_n)); // RQ13 RQ14
    end else begin
      pop = (vis_cnt_r != DCF_CNT_ZERO) & ~read_enable_n & load_select_n; // RQ11 RQ12
    end
  end

  // straps are caught only while reset is applied
  always_comb begin
    fall_through_timing_nxt = fall_through_timing_r;
    psync_nxt = psync_r;
    if (rst) begin
      fall_through_timing_nxt = ~read_expand_in_n & write_expand_in_n; // RQ27
      psync_nxt = first_load_n; // RQ27
    end
  end

  // pointers, counts and visibility delay
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    mem_cnt_nxt = mem_cnt_r;
    vis_cnt_nxt = vis_cnt_r;
    vis_pipe_nxt = vis_pipe_r;
    if (rst) begin
      wr_ptr_nxt = DCF_PTR_ZERO; // RQ1
      rd_ptr_nxt = DCF_PTR_ZERO; // RQ1
      mem_cnt_nxt = DCF_CNT_ZERO;
      vis_cnt_nxt = DCF_CNT_ZERO;
      vis_pipe_nxt = DCF_VIS_ZERO;
    end else begin
      // a write reaches the read side two edges late, which gives the
      // fall-through first word its third-edge latency
      vis_pipe_nxt = {vis_pipe_r[DCF_VIS_LAST-1:0], wr_acc}; // RQ13
      if (wr_acc) begin
        wr_ptr_nxt = wr_ptr_r + DCF_PTR_ONE; // RQ5
      end
      if (pop) begin
        rd_ptr_nxt = rd_ptr_r + DCF_PTR_ONE;
      end
      mem_cnt_nxt = mem_cnt_r + (wr_acc ? DCF_CNT_ONE : DCF_CNT_ZERO)
        - (pop ? DCF_CNT_ONE : DCF_CNT_ZERO);
      vis_cnt_nxt = vis_cnt_r + (vis_pipe_r[DCF_VIS_LAST] ? DCF_CNT_ONE : DCF_CNT_ZERO)
        - (pop ? DCF_CNT_ONE : DCF_CNT_ZERO);
    end
  end

  // output register and fall-through valid bit
  always_comb begin
    dout_nxt = dout_r;
    out_valid_nxt = out_valid_r;
    if (rst) begin
      dout_nxt = DCF_DATA_ZERO; // RQ4
      out_valid_nxt = 1'b0;
    end else if (ofs_rd) begin
      dout_nxt = {DCF_OFS_PAD, ofs_rdata}; // RQ20
    end else if (pop) begin
      dout_nxt = mem_rdata; // RQ11
      out_valid_nxt = 1'b1;
    end else if (fall_through_timing_r & out_valid_r & ~read_enable_n & load_select_n) begin
      // last word taken: data stays, ready flag rises
      out_valid_nxt = 1'b0; // RQ14
    end
  end

  // flags follow the state that the same edge produces
  always_comb begin
    words_nxt = mem_cnt_nxt + ((fall_through_timing_r & out_valid_nxt) ? DCF_CNT_ONE : DCF_CNT_ZERO);
    words_wide = {4'h0, words_nxt};
    flags_nxt = flags_r;
    if (rst) begin
      flags_nxt.full_flag_n = 1'b1; // RQ2
      flags_nxt.almost_full_n = 1'b1; // RQ2
      flags_nxt.half_full_n = 1'b1; // RQ2
      flags_nxt.almost_empty_n = 1'b0; // RQ2
      flags_nxt.empty_flag_n = fall_through_timing_nxt; // RQ3
    end else begin
      if (fall_through_timing_r) begin
        // input ready low while the array or output register has room
        flags_nxt.full_flag_n = (mem_cnt_nxt == DCF_DEPTH_CNT) & out_valid_nxt; // RQ9
        flags_nxt.empty_flag_n = ~out_valid_nxt; // RQ14
      end else begin
        flags_nxt.full_flag_n = mem_cnt_nxt != DCF_DEPTH_CNT; // RQ7 RQ8
        flags_nxt.empty_flag_n = vis_cnt_nxt != DCF_CNT_ZERO; // RQ12
      end
      flags_nxt.almost_empty_n = words_wide >
        ({1'b0, ae_thr} + {12'h000, fall_through_timing_r}); // RQ23
      flags_nxt.almost_full_n = (words_wide + {1'b0, af_thr}) <
        (DCF_DEPTH_WIDE + {12'h000, fall_through_timing_r}); // RQ24
      flags_nxt.half_full_n = words_wide <=
        (DCF_HALF_WIDE + {12'h000, fall_through_timing_r}); // RQ25
    end
  end

  // all state of this module, registered only
  always_ff @(posedge clk_sys) begin
    fall_through_timing_r <= fall_through_timing_nxt;
    psync_r <= psync_nxt;
    wr_ptr_r <= wr_ptr_nxt;
    rd_ptr_r <= rd_ptr_nxt;
    mem_cnt_r <= mem_cnt_nxt;
    vis_cnt_r <= vis_cnt_nxt;
    vis_pipe_r <= vis_pipe_nxt;
    out_valid_r <= out_valid_nxt;
    dout_r <= dout_nxt;
    flags_r <= flags_nxt;
  end

  // word array
  dcf_word_store dcf_word_store_i (
    .clk_sys (clk_sys),
    .wr_en (wr_acc),
    .wr_addr (wr_ptr_r),
    .wr_data (data_in),
    .rd_addr (rd_ptr_r),
    .rd_data (mem_rdata)
  );

  // threshold registers share data_in with the array
  dcf_offset_regs dcf_offset_regs_i (
    .clk_sys (clk_sys),
    .rst (rst),
    .wr_en (ofs_wr),
    .wr_data (data_in[DCF_OW-1:0]),
    .rd_en (ofs_rd),
    .almost_empty_threshold (ae_thr),
    .almost_full_threshold (af_thr),
    .rd_data (ofs_rdata)
  );

  // pins; the bus wire is resolved outside from the enable
  assign qbus.data_out = dout_r;
  assign qbus.data_out_oe = ~output_enable_n; // RQ15
  assign flags = flags_r;
  // one clock here, so both partial flag modes update alike; mode is reported
  assign partial_flags_sync = psync_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // a write into a fully drained fall-through buffer, nothing in flight
  sequence write_into_empty_s;
    fall_through_timing_r && mem_cnt_r == DCF_CNT_ZERO && !out_valid_r && wr_acc;
  endsequence

  // output register stays empty through the write and two more edges
  sequence first_word_shows_s;
    !out_valid_r [*4] ##1 (out_valid_r && !flags.empty_flag_n);
  endsequence

  // true read of the shown word with nothing queued behind it
  sequence last_word_taken_s;
    fall_through_timing_r && out_valid_r && vis_cnt_r == DCF_CNT_ZERO && !read_enable_n && load_select_n;
  endsequence

  // ready flag rises, the old word stays on the bus
  sequence ready_dropped_s;
    flags.empty_flag_n && $stable(dout_r);
  endsequence

  // reset checks drop the default disable, they watch reset itself
  reset_pointer_a: assert property (@(posedge clk_sys) disable iff (1'b0) // RQ1
    rst |=> wr_ptr_r == DCF_PTR_ZERO && rd_ptr_r == DCF_PTR_ZERO)
    else $error("pointers not cleared by reset");
  reset_flags_a: assert property (@(posedge clk_sys) disable iff (1'b0) // RQ2
    rst |=> flags.full_flag_n && flags.almost_full_n && flags.half_full_n
      && !flags.almost_empty_n && qbus.data_out == DCF_DATA_ZERO)
    else $error("reset flag or data value wrong");
  reset_empty_a: assert property (@(posedge clk_sys) disable iff (1'b0) // RQ3
    rst |=> flags.empty_flag_n == fall_through_timing_r)
    else $error("empty flag reset value does not match timing mode");
  // straps count only while reset is applied
  straps_hold_a: assert property (!rst |=> $stable(fall_through_timing_r) && $stable(psync_r)) // RQ27
    else $error("timing mode changed outside reset");

  // full flag as registered is the only write gate
  full_blocks_a: assert property (full_now |=> $stable(wr_ptr_r)) // RQ10
    else $error("write accepted while full");
  // a released write strobe leaves the array alone
  idle_write_a: assert property (write_enable_n |=> wr_ptr_r == $past(wr_ptr_r)) // RQ6
    else $error("write pointer moved without write enable");
  // each accepted write moves the write pointer by one location
  write_step_a: assert property (wr_acc |=> wr_ptr_r == $past(wr_ptr_r) + DCF_PTR_ONE) // RQ5
    else $error("write pointer did not step by one");
  // offset loads share the write strobe but never touch the array
  offset_no_array_a: assert property (ofs_wr |=> $stable(wr_ptr_r)) // RQ16
    else $error("offset load moved the write pointer");

  // standard full flag tracks the array count directly
  std_full_a: assert property (!fall_through_timing_r && mem_cnt_r == DCF_DEPTH_CNT |-> !flags.full_flag_n) // RQ8
    else $error("standard full flag high with the array full");
  // fall-through full counts the output register as the extra word
  fall_full_a: assert property (fall_through_timing_r && mem_cnt_r == DCF_DEPTH_CNT && out_valid_r // RQ9
    |-> flags.full_flag_n)
    else $error("input ready low with array and output register full");
  // first word loads itself, no read strobe needed
  fall_first_a: assert property (write_into_empty_s |-> first_word_shows_s) // RQ13
    else $error("fall-through first word not on third edge");
  fall_ready_a: assert property (last_word_taken_s |=> ready_dropped_s) // RQ14
    else $error("output ready did not rise on the last true read");

  // no read strobe, no change on the output register, except a fall-through auto-load into an empty one
  hold_data_a: assert property (read_enable_n && (!fall_through_timing_r || out_valid_r) // RQ11
    |=> $stable(dout_r))
    else $error("output register changed without a read");
  // standard reads while the empty flag is low are dropped
  std_empty_hold_a: assert property (!fall_through_timing_r && !flags.empty_flag_n && load_select_n // RQ12
    |=> $stable(rd_ptr_r) && $stable(dout_r))
    else $error("read taken while empty");
  // a readback strobe in fall-through must leave the shown word alone
  no_readback_a: assert property (fall_through_timing_r && !load_select_n && out_valid_r // RQ21
    |=> $stable(dout_r))
    else $error("offset readback in fall-through timing");

  // flags lag a threshold load by one edge, so compare only once it settled
  almost_empty_a: assert property (!fall_through_timing_r && $stable(ae_thr) // RQ23
    && {4'h0, mem_cnt_r} <= {1'b0, ae_thr} |-> !flags.almost_empty_n)
    else $error("almost-empty high at or below the empty offset");
  almost_full_a: assert property (!fall_through_timing_r && $stable(af_thr) // RQ24
    && ({4'h0, mem_cnt_r} + {1'b0, af_thr}) >= DCF_DEPTH_WIDE |-> !flags.almost_full_n)
    else $error("almost-full high within the full offset of depth");
  // half-full compares against the packed half-depth constant
  half_full_a: assert property (mem_cnt_r > DCF_HALF_WIDE[8:0] && !fall_through_timing_r // RQ25
    |-> !flags.half_full_n)
    else $error("half-full high above half occupancy");
endmodule

// ### test/dcf_host_model.sv
// producer and consumer model that drives the fifo pins
`timescale 1ns/1ns
module dcf_host_model
  import dcf_pkg::*;
(
  input wire logic clk_sys,
  output logic rst,
  output logic [DCF_DW-1:0] data_in,
  output logic write_enable_n,
  output logic load_select_n,
  output logic read_enable_n,
  output logic output_enable_n,
  output logic first_load_n,
  output logic read_expand_in_n,
  output logic write_expand_in_n
);
  // quiet pins at time zero, reset asserted until a scenario releases it
  initial begin
    rst = 1'b1;
    data_in = 18'h0_0000;
    write_enable_n = 1'b1;
    load_select_n = 1'b1;
    read_enable_n = 1'b1;
    output_enable_n = 1'b0;
    first_load_n = 1'b0;
    read_expand_in_n = 1'b0;
    write_expand_in_n = 1'b0;
  end

  // reset with straps; fall-through needs one more edge before a write
  task automatic do_reset(input logic fall_through_timing, input logic fl);
    @(posedge clk_sys);
    rst <= 1'b1;
    write_expand_in_n <= fall_through_timing;
    first_load_n <= fl;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // back-to-back array writes; data bus scrambled once released
  task automatic push(input int n, input logic [17:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      write_enable_n <= 1'b0;
      data_in <= base + 18'(i);
    end
    @(posedge clk_sys);
    write_enable_n <= 1'b1;
    data_in <= ~data_in;
    #1;
  endtask

  // one offset access; never a read and a write together
  task automatic ldacc(input logic wr, input logic rd, input logic [11:0] val);
    @(posedge clk_sys);
    load_select_n <= 1'b0;
    write_enable_n <= ~wr;
    read_enable_n <= ~rd;
    data_in <= {6'h00, val};
    @(posedge clk_sys);
    load_select_n <= 1'b1;
    write_enable_n <= 1'b1;
    read_enable_n <= 1'b1;
    data_in <= ~data_in;
    #1;
  endtask

  // output enable level, changed just after an edge
  task automatic set_oe(input logic v);
    @(posedge clk_sys);
    output_enable_n <= v;
    #1;
  endtask

  // one read request; in standard timing every word is asked for explicitly
  task automatic rd;
    @(posedge clk_sys);
    read_enable_n <= 1'b0;
    @(posedge clk_sys);
    read_enable_n <= 1'b1;
    #1;
  endtask
endmodule

// ### test/dcf_fifo_test.sv
// self-checking bench for the fifo in both timing modes
`timescale 1ns/1ns
module dcf_fifo_test;
  import dcf_pkg::*;
  logic clk_sys; // system clock
  logic rst, wen_n, ld_n, ren_n, oe_n, fl_n, rxi_n, wxi_n;
  logic [DCF_DW-1:0] data_in;
  dcf_qbus_type qbus;
  dcf_flags_type flags;
  logic psync; // partial flag mode as reported
  int bad_count;
  int checks;

  dcf_fifo dcf_fifo_i(.clk_sys(clk_sys), .rst(rst), .data_in(data_in),
    .write_enable_n(wen_n), .load_select_n(ld_n), .read_enable_n(ren_n),
    .output_enable_n(oe_n), .first_load_n(fl_n), .read_expand_in_n(rxi_n),
    .write_expand_in_n(wxi_n), .qbus(qbus), .flags(flags), .partial_flags_sync(psync));
  dcf_host_model dcf_host_model_i(.clk_sys(clk_sys), .rst(rst), .data_in(data_in),
    .write_enable_n(wen_n), .load_select_n(ld_n), .read_enable_n(ren_n),
    .output_enable_n(oe_n), .first_load_n(fl_n), .read_expand_in_n(rxi_n),
    .write_expand_in_n(wxi_n));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic final_report;
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // compare one value, four-state exact
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait for one flag bit; flags lag writes by a few edges
  task automatic wait_flag(input int idx, input logic val);
    int k;
    k = 0;
    while (flags[idx] !== val && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("flag wait", 18'(val), 18'(flags[idx]));
    if (flags[idx] !== val) final_report();
  endtask

  // reset levels in standard timing
  task automatic t_reset;
    dcf_host_model_i.do_reset(1'b0, 1'b0);
    chk("reset flags", 18'h0_001c, 18'(flags));
    chk("flag mode", 18'h0_0000, 18'(psync));
    chk("reset data", 18'h0_0000, qbus.data_out);
    chk("drive on", 18'h0_0001, 18'(qbus.data_out_oe));
  endtask

  // defaults, rotation, idle load edges, readback with own pointer
  task automatic t_offsets;
    logic [11:0] exp_q [5];
    exp_q = '{12'h01f, 12'h01f, 12'h003, 12'h05a, 12'h003};
    for (int i = 0; i < 5; i++) begin
      // defaults read first, then load and read the rotation back
      if (i == 2) begin
        dcf_host_model_i.ldacc(1'b1, 1'b0, 12'h0a5);
        dcf_host_model_i.ldacc(1'b0, 1'b0, 12'h777);
        dcf_host_model_i.ldacc(1'b1, 1'b0, 12'h05a);
        dcf_host_model_i.ldacc(1'b1, 1'b0, 12'h003);
      end
      dcf_host_model_i.ldacc(1'b0, 1'b1, 12'h000);
      chk("offset read", {6'h00, exp_q[i]}, qbus.data_out);
    end
  endtask

  // fill to full with thresholds n=3 m=90, overrun, drain, empty read
  task automatic t_fill;
    dcf_host_model_i.push(3, 18'h2_0000);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("almost empty", 18'h0_0000, 18'(flags.almost_empty_n));
    dcf_host_model_i.push(1, 18'h2_0003);
    wait_flag(1, 1'b1);
    dcf_host_model_i.push(124, 18'h2_0004);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("half at 128", 18'h0_0001, 18'(flags.half_full_n));
    dcf_host_model_i.push(1, 18'h2_0080);
    wait_flag(2, 1'b0);
    dcf_host_model_i.push(36, 18'h2_0081);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("almost full 165", 18'h0_0001, 18'(flags.almost_full_n));
    dcf_host_model_i.push(1, 18'h2_00a5);
    wait_flag(3, 1'b0);
    dcf_host_model_i.push(89, 18'h2_00a6);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("full at 255", 18'h0_0001, 18'(flags.full_flag_n));
    dcf_host_model_i.push(1, 18'h2_00ff);
    wait_flag(4, 1'b0);
    dcf_host_model_i.push(1, 18'h3_ffff);
    for (int i = 0; i < 256; i++) begin
      wait_flag(0, 1'b1);
      dcf_host_model_i.rd();
      chk("read word", 18'h2_0000 + 18'(i), qbus.data_out);
      if (i == 0) wait_flag(4, 1'b1);
    end
    wait_flag(0, 1'b0);
    dcf_host_model_i.rd();
    chk("empty read", 18'h2_00ff, qbus.data_out);
    dcf_host_model_i.set_oe(1'b1);
    chk("drive off", 18'h0_0000, 18'(qbus.data_out_oe));
  endtask

  // fall-through: self-loading first word, blocked readback, true read
  task automatic t_fall_through_timing;
    dcf_host_model_i.do_reset(1'b1, 1'b1);
    chk("fall_through_timing ready", 18'h0_0001, 18'(flags.empty_flag_n));
    chk("flag mode", 18'h0_0001, 18'(psync));
    chk("input ready", 18'h0_0000, 18'(flags.full_flag_n));
    dcf_host_model_i.push(1, 18'h1_5555);
    wait_flag(0, 1'b0);
    chk("first word", 18'h1_5555, qbus.data_out);
    dcf_host_model_i.ldacc(1'b0, 1'b1, 12'h000);
    chk("no readback", 18'h1_5555, qbus.data_out);
    dcf_host_model_i.rd();
    wait_flag(0, 1'b1);
    dcf_host_model_i.rd();
    chk("held word", 18'h1_5555, qbus.data_out);
  endtask

  // main sequence
  initial begin
    bad_count = 0;
    checks = 0;
    t_reset();
    t_offsets();
    t_fill();
    t_fall_through_timing();
    final_report();
  end
endmodule
